// ---- hw/sprc_pkg.sv ----
// package for the sleep, power and reset control block
package sprc_pkg;
    // register indices: the byte address on the bus is four times the index
    localparam logic [31:0] SPRC_OFS_SLEEP_CTRL = 32'h0000_0030;
    localparam logic [31:0] SPRC_OFS_CLK_GATE = 32'h0000_0035;
    localparam logic [31:0] SPRC_OFS_PROTECT_KEY = 32'h0000_0038;
    localparam logic [31:0] SPRC_OFS_RESET_STATUS = 32'h0000_003C;
    localparam logic [7:0] SPRC_KEY_SIGNATURE = 8'hD8;
    localparam logic [2:0] SPRC_PROTECT_CYCLES = 3'h4;
    localparam int SPRC_BIT_BOD_OFF = 4;
    localparam int SPRC_BIT_SEL_LO = 1;
    localparam int SPRC_BIT_SLEEP_EN = 0;
    localparam logic [7:0] SPRC_CTRL_RESET = 8'h00;
    localparam logic [7:0] SPRC_CTRL_MASK = 8'h1F;
    localparam logic [7:0] SPRC_GATE_RESET = 8'h00;
    localparam logic [7:0] SPRC_GATE_MASK = 8'h1F;
    localparam int SPRC_GATE_BITS = 5;
    localparam int SPRC_STARTUP_CYCLES = 64;
    localparam logic [2:0] SPRC_SEL_IDLE = 3'h0;
    localparam logic [2:0] SPRC_SEL_ADC_NR = 3'h1;
    localparam logic [2:0] SPRC_SEL_POWER_DOWN = 3'h2;
    localparam logic [2:0] SPRC_SEL_STANDBY = 3'h4;
    localparam logic [1:0] SPRC_RESP_OKAY = 2'h0;
    localparam logic [1:0] SPRC_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {SPRC_RUN, SPRC_SLEEP, SPRC_HOLD} sprc_state_t;

    typedef struct packed {
        logic cpu_mem;
        logic io;
        logic osc;
        logic other;
    } sprc_clk_stop_t;

    typedef struct packed {
        logic por_low;
        logic ext_low;
        logic wdt_pulse;
        logic bod_low;
    } sprc_rst_src_t;
endpackage

// ---- hw/sprc_top.sv ----
// sleep, power and reset control with axi4-lite register slave
// Contract
// - setting brownout sleep-off needs signature then write within four cycles
// - detector off for sleep only when sleep executes with sleep-off set
// - sleep-off bit cleared by hardware on wake
// - writing zero to sleep-off clears it with no signature
// - three-bit sleep select: idle, adc noise, power-down, standby; others reserved
// - sleep instruction sleeps only while sleep-enable bit is one
// - clock gating upper three bits read zero; all bits reset zero
// - gating bits stop two-wire, spi, timer1, timer0, adc clocks
// - gated timer resumes from state held before shutdown
// - comparator cannot use adc input mux while adc gated
// - any reset returns registers to initial values, restarts at reset vector
// - port pins go to initial state asynchronously when any reset source active; here port_reset is registered and rises one clock after the source
// - delay counter holds internal reset after all sources release
// - internal reset combines power-on, pin, watchdog and brownout sources
// - power-on reset reasserts internal reset immediately
// - pin reset ignored during power-on count; release restarts delay count
// - after power-on, reset extended only if pin still low at count end
// - watchdog pulse; delay count starts on its falling edge
// - brownout asserts reset at once; release starts delay count
// - reference on when brownout enabled, bandgap select, or adc enabled
// - per-mode clock stops for idle, adc noise, power-down, standby
// - sleep-off acts only in power-down and standby; resets to zero
// - gated peripheral frozen, its registers not accessible
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/10ps
module sprc_top #(
    parameter int STARTUP_CYCLES = sprc_pkg::SPRC_STARTUP_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic por_low,
    input wire logic ext_reset_n,
    input wire logic wdt_timeout,
    input wire logic bod_low,
    input wire logic bod_fuse_enable,
    input wire logic comparator_bandgap_select,
    input wire logic adc_enable,
    input wire logic sleep_exec,
    input wire logic wake_event,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic internal_reset,
    output logic port_reset,
    output logic sleeping,
    output logic [2:0] sleep_mode_out,
    output sprc_pkg::sprc_clk_stop_t clk_stop,
    output logic [4:0] periph_clk_gate,
    output logic comparator_mux_allow,
    output logic brownout_detector_on,
    output logic vref_enable
);
    import sprc_pkg::*;

    typedef struct packed {
        logic aw_held;
        logic [31:0] aw_addr;
        logic w_held;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic brownout_sleep_off;
        logic [2:0] sleep_select;
        logic sleep_enable_bit;
        logic [4:0] gate;
        logic [2:0] protect_cnt;
        sprc_state_t state;
        logic bod_cut;
        logic [31:0] delay_cnt;
        logic por_phase;
        logic bod_on;
        sprc_clk_stop_t stop;
        logic ireset;
        logic preset;
        logic vref;
        logic cmp_allow;
        logic [3:0] rst_cause;
    } sprc_regs_t;

    sprc_regs_t s_q;
    sprc_regs_t s_d;
    logic src_active;
    logic wr_fire;
    logic rd_fire;
    logic protect_open;
    logic [2:0] sel;
    logic [7:0] wbyte;
    logic bod_enabled;
    logic [31:0] wr_idx;
    logic [31:0] rd_idx;

    // brownout counts only when fused on and not cut for sleep
    assign bod_enabled = bod_fuse_enable && !s_q.bod_cut;
    // power-on hides the pin during its own count, so the pin term waits for por_phase to end
    assign src_active = por_low || (!ext_reset_n && !s_q.por_phase) || wdt_timeout
        || (bod_low && bod_enabled);
    assign protect_open = s_q.protect_cnt != 3'h0;
    assign wr_fire = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    assign rd_fire = s_axi_arvalid && !s_q.rvalid;
    assign wbyte = s_q.w_data;
    assign sel = s_q.sleep_select;
    // registers sit on word boundaries, so the low two address bits are dropped
    assign wr_idx = {2'b00, s_q.aw_addr[31:2]};
    assign rd_idx = {2'b00, s_axi_araddr[31:2]};

    always_comb begin
        s_d = s_q;
        // write channels, taken in either order
        if (s_axi_awvalid && !s_q.aw_held) begin
            s_d.aw_held = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_held) begin
            s_d.w_held = 1'b1;
            s_d.w_data = s_axi_wdata[7:0];
            s_d.w_lane0 = s_axi_wstrb[0];
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.protect_cnt != 3'h0) begin
            s_d.protect_cnt = s_q.protect_cnt - 3'h1;
        end
        if (wr_fire) begin
            s_d.aw_held = 1'b0;
            s_d.w_held = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = SPRC_RESP_OKAY;
            if (!s_q.w_lane0) begin
                s_d.bresp = SPRC_RESP_OKAY;
            end else if (wr_idx == SPRC_OFS_SLEEP_CTRL) begin
                s_d.sleep_select = wbyte[SPRC_BIT_SEL_LO +: 3];
                s_d.sleep_enable_bit = wbyte[SPRC_BIT_SLEEP_EN];
                if (!wbyte[SPRC_BIT_BOD_OFF]) begin
                    s_d.brownout_sleep_off = 1'b0;
                end else if (protect_open) begin
                    s_d.brownout_sleep_off = 1'b1;
                end
            end else if (wr_idx == SPRC_OFS_CLK_GATE) begin
                s_d.gate = wbyte[SPRC_GATE_BITS-1:0];
            end else if (wr_idx == SPRC_OFS_PROTECT_KEY) begin
                if (wbyte == SPRC_KEY_SIGNATURE) begin
                    s_d.protect_cnt = SPRC_PROTECT_CYCLES;
                end
            end else if (wr_idx != SPRC_OFS_RESET_STATUS) begin
                s_d.bresp = SPRC_RESP_SLVERR;
            end
        end
        // read channel
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (rd_fire) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = SPRC_RESP_OKAY;
            s_d.rdata = 32'h0000_0000;
            if (rd_idx == SPRC_OFS_SLEEP_CTRL) begin
                s_d.rdata[7:0] = {3'h0, s_q.brownout_sleep_off, s_q.sleep_select, s_q.sleep_enable_bit};
            end else if (rd_idx == SPRC_OFS_CLK_GATE) begin
                s_d.rdata[7:0] = {3'h0, s_q.gate};
            end else if (rd_idx == SPRC_OFS_PROTECT_KEY) begin
                s_d.rdata[7:0] = {5'h00, s_q.protect_cnt};
            end else if (rd_idx == SPRC_OFS_RESET_STATUS) begin
                s_d.rdata[7:0] = {3'h0, s_q.state == SPRC_SLEEP, s_q.rst_cause};
            end else begin
                s_d.rresp = SPRC_RESP_SLVERR;
            end
        end
        // sleep sequencing
        unique case (s_q.state)
            SPRC_RUN: begin
                if (sleep_exec && s_q.sleep_enable_bit) begin
                    s_d.state = SPRC_SLEEP;
                    s_d.bod_cut = s_q.brownout_sleep_off
                        && (sel == SPRC_SEL_POWER_DOWN || sel == SPRC_SEL_STANDBY);
                    s_d.stop.cpu_mem = 1'b1;
                    s_d.stop.io = sel != SPRC_SEL_IDLE;
                    s_d.stop.other = sel == SPRC_SEL_POWER_DOWN || sel == SPRC_SEL_STANDBY;
                    s_d.stop.osc = sel == SPRC_SEL_POWER_DOWN;
                end
            end
            SPRC_SLEEP: begin
                if (wake_event) begin
                    s_d.state = SPRC_RUN;
                    s_d.bod_cut = 1'b0;
                    s_d.stop = '0;
                    s_d.brownout_sleep_off = 1'b0;
                end
            end
            SPRC_HOLD: begin
                s_d.state = SPRC_HOLD;
            end
        endcase
        // reset combining and stretch
        if (src_active) begin
            s_d.preset = 1'b1;
            s_d.ireset = 1'b1;
            s_d.delay_cnt = 32'h0000_0000;
            // only sources that actually count are recorded
            s_d.rst_cause = s_q.rst_cause
                | {por_low, !ext_reset_n && !s_q.por_phase, wdt_timeout, bod_low && bod_enabled};
            if (por_low) begin
                s_d.por_phase = 1'b1;
            end
        end else if (s_q.ireset) begin
            // count restarts whenever a source is seen, so a watchdog pulse times from its fall
            if (s_q.delay_cnt >= 32'(STARTUP_CYCLES - 1)) begin
                s_d.por_phase = 1'b0;
                if (!(s_q.por_phase && !ext_reset_n)) begin
                    s_d.ireset = 1'b0;
                end
            end else begin
                s_d.delay_cnt = s_q.delay_cnt + 32'h1;
            end
        end
        if (!src_active) begin
            s_d.preset = 1'b0;
        end
        if (s_q.ireset) begin
            // registers held at initial value while reset stands
            s_d.brownout_sleep_off = 1'b0;
            s_d.sleep_select = 3'h0;
            s_d.sleep_enable_bit = 1'b0;
            s_d.gate = SPRC_GATE_RESET[4:0];
            s_d.protect_cnt = 3'h0;
            s_d.state = SPRC_RUN;
            s_d.stop = '0;
            s_d.bod_cut = 1'b0;
        end
        s_d.vref = bod_fuse_enable || comparator_bandgap_select || adc_enable;
        s_d.bod_on = bod_fuse_enable && !s_d.bod_cut;
        s_d.cmp_allow = !s_d.gate[0];
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '0;
            s_q.ireset <= 1'b1;
            s_q.preset <= 1'b1;
            s_q.por_phase <= 1'b1;
            s_q.state <= SPRC_RUN;
        end else begin
            s_q <= s_d;
        end
    end

    // single-bit gating leaves peripheral state untouched, which is what makes resume exact
    assign periph_clk_gate = s_q.gate;
    assign s_axi_awready = !s_q.aw_held;
    assign s_axi_wready = !s_q.w_held;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign internal_reset = s_q.ireset;
    assign port_reset = s_q.preset;
    assign sleeping = s_q.state == SPRC_SLEEP;
    assign sleep_mode_out = s_q.sleep_select;
    assign clk_stop = s_q.stop;
    assign comparator_mux_allow = s_q.cmp_allow;
    assign brownout_detector_on = s_q.bod_on;
    assign vref_enable = s_q.vref;

    int unsigned hold_cnt;
    always_ff @(posedge clk_sys) begin
        if (rst || src_active || !s_q.ireset) begin
            hold_cnt <= 0;
        end else begin
            hold_cnt <= hold_cnt + 1;
        end
    end

    sequence key_written;
        wr_fire && s_q.w_lane0 && wr_idx == SPRC_OFS_PROTECT_KEY && wbyte == SPRC_KEY_SIGNATURE && !s_q.ireset;
    endsequence

    a_key_loads_window: assert property (@(posedge clk_sys) disable iff (rst)
        key_written |=> s_q.protect_cnt == SPRC_PROTECT_CYCLES)
        else $error("window not loaded by signature");
    a_window_closes: assert property (@(posedge clk_sys) disable iff (rst)
        (s_q.protect_cnt == 3'h0 && !s_q.brownout_sleep_off) |=> !s_q.brownout_sleep_off)
        else $error("sleep-off set without open window");
    a_zero_clears_bod: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_fire && s_q.w_lane0 && wr_idx == SPRC_OFS_SLEEP_CTRL && !wbyte[SPRC_BIT_BOD_OFF])
        |=> !s_q.brownout_sleep_off)
        else $error("zero write did not clear sleep-off");
    a_wake_clears_bod: assert property (@(posedge clk_sys) disable iff (rst)
        (s_q.state == SPRC_SLEEP && wake_event) |=> !s_q.brownout_sleep_off && !sleeping)
        else $error("wake left sleep-off set");
    a_sleep_needs_enable: assert property (@(posedge clk_sys) disable iff (rst)
        (!sleeping && !s_q.sleep_enable_bit) |=> !sleeping)
        else $error("slept without enable");
    a_bod_cut_mode: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(s_q.bod_cut) |-> $past(sel) == SPRC_SEL_POWER_DOWN || $past(sel) == SPRC_SEL_STANDBY)
        else $error("detector cut in wrong mode");
    a_source_asserts: assert property (@(posedge clk_sys) disable iff (rst)
        src_active |=> internal_reset && port_reset)
        else $error("reset source not seen next cycle");
    a_stretch_length: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(internal_reset) |-> hold_cnt >= STARTUP_CYCLES - 1)
        else $error("reset released before count");
    a_gate_upper_zero: assert property (@(posedge clk_sys) disable iff (rst)
        (s_axi_rvalid && $rose(s_axi_rvalid) && $past(rd_idx) == SPRC_OFS_CLK_GATE)
        |-> s_axi_rdata[7:5] == 3'h0)
        else $error("gating upper bits not zero");
    a_vref_follows: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 vref_enable == $past(bod_fuse_enable || comparator_bandgap_select || adc_enable))
        else $error("reference enable wrong");
    a_bod_on_follows: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 brownout_detector_on == ($past(bod_fuse_enable) && !s_q.bod_cut))
        else $error("detector enable wrong");
    a_mux_follows_gate: assert property (@(posedge clk_sys) disable iff (rst)
        comparator_mux_allow |-> !periph_clk_gate[0])
        else $error("comparator mux open while converter gated");
    a_pin_extends: assert property (@(posedge clk_sys) disable iff (rst)
        (!src_active && s_q.ireset && s_q.por_phase && !ext_reset_n
        && s_q.delay_cnt >= 32'(STARTUP_CYCLES - 1)) |=> internal_reset)
        else $error("reset released with pin low after power-on count");
endmodule

// ---- verif/sprc_core_model.sv ----
// core-side model: axi4-lite master plus sleep and wake pulses
`timescale 1ns/10ps
module sprc_core_model (
    input wire logic clk_sys,
    output logic [31:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [31:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready,
    output logic sleep_exec,
    output logic wake_event
);
    initial {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sleep_exec, wake_event} = 7'h00;
    initial {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    assign s_axi_wstrb = 4'hF;
    // a is a register index; the bus carries four times it
    // lag 0 keeps a key and its protected write inside the short window
    task automatic wr(input logic [31:0] a, input logic [7:0] v, input int lag, output logic [1:0] r);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= {a[29:0], 2'b00};
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk_sys);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~{24'h0, v};
            end
        end
        repeat (lag) @(posedge clk_sys);
        s_axi_bready <= 1'b1;
        do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= {a[29:0], 2'b00};
        s_axi_arvalid <= 1'b1;
        do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        s_axi_rready <= 1'b1;
        do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic pulse(input logic wake);
        {wake_event, sleep_exec} <= wake ? 2'b10 : 2'b01;
        @(posedge clk_sys);
        {wake_event, sleep_exec} <= 2'b00;
    endtask
endmodule

// ---- verif/tb_sleep_power_reset_control.sv ----
// testbench: reset sources, sleep modes, protected bit, clock gating, reference enable
`timescale 1ns/10ps
module tb_sleep_power_reset_control;
    import sprc_pkg::*;
    localparam int SC = 8;
    localparam logic [2:0] MODES [4] = '{SPRC_SEL_IDLE, SPRC_SEL_ADC_NR, SPRC_SEL_POWER_DOWN, SPRC_SEL_STANDBY};
    localparam logic [3:0] STOPS [4] = '{4'h8, 4'hC, 4'hF, 4'hD};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic por_low = 1'b0, ext_reset_n = 1'b1, wdt_timeout = 1'b0, bod_low = 1'b0;
    logic bod_fuse_enable = 1'b0, comparator_bandgap_select = 1'b0, adc_enable = 1'b0;
    logic sleep_exec, wake_event, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, internal_reset, port_reset;
    logic sleeping, comparator_mux_allow, brownout_detector_on, vref_enable;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [2:0] sleep_mode_out;
    logic [4:0] periph_clk_gate;
    logic [7:0] v;
    sprc_clk_stop_t clk_stop;
    int miscompares = 0;
    int n_tests = 0;
    int n;
    always #5 clk_sys = ~clk_sys;
    sprc_top #(.STARTUP_CYCLES(SC)) i_dut (.clk_sys, .rst, .por_low, .ext_reset_n, .wdt_timeout, .bod_low,
        .bod_fuse_enable, .comparator_bandgap_select, .adc_enable, .sleep_exec, .wake_event, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .internal_reset, .port_reset, .sleeping, .sleep_mode_out, .clk_stop,
        .periph_clk_gate, .comparator_mux_allow, .brownout_detector_on, .vref_enable);
    sprc_core_model i_core (.clk_sys, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_exec, .wake_event);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] val);
        i_core.wr(a, val, $urandom_range(2, 0), r);
        chk(32'(r), 32'(SPRC_RESP_OKAY));
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [7:0] exp);
        i_core.rd(a, d, r);
        chk(32'(r), 32'(SPRC_RESP_OKAY));
        chk(d, 32'(exp));
    endtask
    task automatic prot(input logic [7:0] val);
        i_core.wr(SPRC_OFS_PROTECT_KEY, SPRC_KEY_SIGNATURE, 0, r);
        i_core.wr(SPRC_OFS_SLEEP_CTRL, val, 0, r);
    endtask
    // pre counts edges already spent since the last source went away
    task automatic wait_rel(input int pre);
        n = pre;
        while (internal_reset === 1'b1 && n < 300) begin
            @(posedge clk_sys);
            n++;
        end
        chk(32'(n >= SC && n <= SC + 2), 32'h1);
    endtask
    initial begin
        void'($urandom(31));
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk(32'(internal_reset), 32'h1);
        wait_rel(0);
        rdchk(SPRC_OFS_SLEEP_CTRL, SPRC_CTRL_RESET);
        rdchk(SPRC_OFS_CLK_GATE, SPRC_GATE_RESET);
        i_core.rd(32'h0000_0044, d, r);
        chk(32'(r), 32'(SPRC_RESP_SLVERR));
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'hFF : 8'($urandom);
            adc_enable <= 1'b0;
            wr(SPRC_OFS_CLK_GATE, v);
            rdchk(SPRC_OFS_CLK_GATE, v & SPRC_GATE_MASK);
            chk(32'(periph_clk_gate), 32'(v[4:0]));
            chk(32'(comparator_mux_allow), 32'(!v[0]));
        end
        wr(SPRC_OFS_CLK_GATE, 8'h00);
        for (int i = 0; i < 8; i++) begin
            {bod_fuse_enable, comparator_bandgap_select, adc_enable} <= 3'(i);
            repeat (3) @(posedge clk_sys);
            chk(32'(vref_enable), 32'(i != 0));
        end
        {bod_fuse_enable, comparator_bandgap_select, adc_enable} <= 3'b100;
        wr(SPRC_OFS_SLEEP_CTRL, 8'h10);
        rdchk(SPRC_OFS_SLEEP_CTRL, 8'h00);
        prot(8'h10);
        rdchk(SPRC_OFS_SLEEP_CTRL, 8'h10);
        wr(SPRC_OFS_SLEEP_CTRL, 8'h00);
        rdchk(SPRC_OFS_SLEEP_CTRL, 8'h00);
        i_core.wr(SPRC_OFS_PROTECT_KEY, SPRC_KEY_SIGNATURE, 0, r);
        repeat (6) @(posedge clk_sys);
        i_core.wr(SPRC_OFS_SLEEP_CTRL, 8'h10, 0, r);
        rdchk(SPRC_OFS_SLEEP_CTRL, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(SPRC_OFS_SLEEP_CTRL, {4'h0, MODES[i], 1'b0});
            i_core.pulse(1'b0);
            @(posedge clk_sys);
            chk(32'(sleeping), 32'h0);
            prot({4'h1, MODES[i], 1'b1});
            i_core.pulse(1'b0);
            @(posedge clk_sys);
            chk(32'(sleeping), 32'h1);
            chk(32'(sleep_mode_out), 32'(MODES[i]));
            chk(32'(clk_stop), 32'(STOPS[i]));
            chk(32'(brownout_detector_on), 32'(!(MODES[i][1] | MODES[i][2])));
            i_core.pulse(1'b1);
            @(posedge clk_sys);
            chk(32'(sleeping), 32'h0);
            chk(32'(brownout_detector_on), 32'h1);
            rdchk(SPRC_OFS_SLEEP_CTRL, {4'h0, MODES[i], 1'b1});
            wr(SPRC_OFS_SLEEP_CTRL, 8'h00);
        end
        {bod_fuse_enable, bod_low} <= 2'b01;
        repeat (3) @(posedge clk_sys);
        chk(32'(internal_reset), 32'h0);
        {bod_fuse_enable, bod_low} <= 2'b10;
        for (int s = 0; s < 4; s++) begin
            wr(SPRC_OFS_CLK_GATE, 8'h1F);
            {por_low, ext_reset_n, wdt_timeout, bod_low} <= 4'b0100 ^ (4'h8 >> s);
            @(posedge clk_sys);
            wdt_timeout <= 1'b0;
            @(posedge clk_sys);
            chk(32'(internal_reset), 32'h1);
            chk(32'(port_reset), 32'h1);
            repeat (3) @(posedge clk_sys);
            {por_low, ext_reset_n, bod_low} <= 3'b010;
            if (s == 0) begin
                repeat (2) @(posedge clk_sys);
                ext_reset_n <= 1'b0;
                @(posedge clk_sys);
                ext_reset_n <= 1'b1;
            end
            wait_rel((s == 2) ? 4 : ((s == 0) ? 3 : 0));
            rdchk(SPRC_OFS_CLK_GATE, 8'h00);
            i_core.rd(SPRC_OFS_RESET_STATUS, d, r);
            chk(32'(d[3 - s]), 32'h1);
        end
        // pin still low when the power-on count ends keeps reset until the pin lets go
        por_low <= 1'b1;
        repeat (2) @(posedge clk_sys);
        {por_low, ext_reset_n} <= 2'b00;
        repeat (SC + 4) @(posedge clk_sys);
        chk(32'(internal_reset), 32'h1);
        ext_reset_n <= 1'b1;
        wait_rel(0);
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        report_and_stop();
    end
endmodule
